// ### src/tpiu_pkg.sv
package tpiu_pkg;

    // *****************************************
    // Register byte offsets
    // *****************************************
    localparam logic [7:0] OFS_MODE = 8'h00;
    localparam logic [7:0] OFS_CNT1 = 8'h04;
    localparam logic [7:0] OFS_PRE1 = 8'h08;
    localparam logic [7:0] OFS_CNT0 = 8'h0c;
    localparam logic [7:0] OFS_PRE0 = 8'h10;
    localparam logic [7:0] OFS_PRIO = 8'h14;
    localparam logic [7:0] OFS_REQ  = 8'h18;
    localparam logic [7:0] OFS_MASK = 8'h1c;

    // *****************************************
    // Field positions
    // *****************************************
    localparam int MB_LOAD0  = 0;
    localparam int MB_RUN0   = 1;
    localparam int MB_LOAD1  = 2;
    localparam int MB_RUN1   = 3;
    localparam int MB_TIN_LO = 4;
    localparam int MB_TIN_HI = 5;
    localparam int PB_CONT   = 0;
    localparam int PB_INT    = 1;
    localparam int PB_DIV_LO = 2;
    localparam int PB_DIV_HI = 7;
    localparam int MK_GLOBAL = 7;
    localparam int NSRC      = 6;

    // Request source indices
    localparam int SRC_FALL_B = 0;
    localparam int SRC_FALL_C = 1;
    localparam int SRC_FALL_A = 2;
    localparam int SRC_RISE_B = 3;
    localparam int SRC_T0     = 4;
    localparam int SRC_T1     = 5;

    // *****************************************
    // Reset values and counts
    // *****************************************
    localparam logic [7:0]  MODE_RST  = 8'h00;
    localparam logic [7:0]  BYTE_RST  = 8'h00;
    localparam logic [2:0]  PRIO_RST  = 3'h0;
    localparam logic [5:0]  REQ_RST   = 6'h00;
    localparam logic [31:0] RD_ZERO   = 32'h0000_0000;
    localparam logic [1:0]  DIV4_LAST = 2'h3;
    localparam logic [5:0]  PRE_TERM  = 6'h01;
    localparam logic [7:0]  CNT_TERM  = 8'h01;
    localparam logic [7:0]  CNT_ZERO  = 8'h00;
    localparam logic [3:0]  NSRC_W    = 4'h6;

    typedef enum logic [1:0] {
        TIN_EXTCLK = 2'h0,
        TIN_GATE   = 2'h1,
        TIN_TRIG   = 2'h2,
        TIN_RETRIG = 2'h3
    } tpiu_tin_e;

    typedef enum logic [1:0] {
        TS_IDLE = 2'b01,
        TS_RUN  = 2'b10
    } tpiu_tstate_e;

endpackage : tpiu_pkg

// ### src/tpiu_tmr_if.sv
`timescale 1ns/1ns
interface tpiu_tmr_if;
    logic       tick;
    logic       load;
    logic       run;
    logic       cont;
    logic [7:0] init_val;
    logic [5:0] pre_val;
    logic [7:0] count;
    logic       busy;
    logic       eoc;

    modport ctl (output tick, load, run, cont, init_val, pre_val,
                 input count, busy, eoc);
    modport tmr (input tick, load, run, cont, init_val, pre_val,
                 output count, busy, eoc);
endinterface : tpiu_tmr_if

// ### src/tpiu_timer.sv
`timescale 1ns/1ns
module tpiu_timer
    import tpiu_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    tpiu_tmr_if.tmr  bus
);

    tpiu_tstate_e state_ff;
    tpiu_tstate_e nxt_state;
    logic [7:0]   cnt_ff;
    logic [7:0]   nxt_cnt;
    logic [5:0]   pre_ff;
    logic [5:0]   nxt_pre;
    logic         eoc_ff;
    logic         nxt_eoc;

    // *****************************************
    // Prescaler and down counter
    // *****************************************
    always_comb
    begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        nxt_pre   = pre_ff;
        nxt_eoc   = 1'b0;
        if (bus.load)
        begin
            nxt_cnt   = bus.init_val;
            nxt_pre   = bus.pre_val;
            nxt_state = TS_RUN;
        end
        else
        begin
            unique case (state_ff)
                TS_IDLE: nxt_state = TS_IDLE;
                TS_RUN:
                begin
                    if (bus.run && bus.tick)
                    begin
                        if (pre_ff == PRE_TERM)
                        begin
                            nxt_pre = bus.pre_val;
                            if (cnt_ff == CNT_TERM)
                            begin
                                nxt_eoc = 1'b1;
                                if (bus.cont)
                                    nxt_cnt = bus.init_val;
                                else
                                begin
                                    nxt_cnt   = CNT_ZERO;
                                    nxt_state = TS_IDLE;
                                end
                            end
                            else
                                nxt_cnt = cnt_ff - CNT_TERM;
                        end
                        else
                            nxt_pre = pre_ff - PRE_TERM;
                    end
                end
                default: nxt_state = TS_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_ff <= TS_IDLE;
            cnt_ff   <= CNT_ZERO;
            pre_ff   <= PRE_TERM;
            eoc_ff   <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
            pre_ff   <= nxt_pre;
            eoc_ff   <= nxt_eoc;
        end
    end

    assign bus.count = cnt_ff;
    assign bus.busy  = (state_ff == TS_RUN);
    assign bus.eoc   = eoc_ff;

    // *****************************************
    // Assertions
    // *****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    a_load_restarts: assert property (
        bus.load |=> (cnt_ff == $past(bus.init_val)) && state_ff == TS_RUN)
        else $error("load did not restart counter");
    a_single_halts: assert property (
        (!bus.load && state_ff == TS_RUN && bus.run && bus.tick && !bus.cont
         && pre_ff == PRE_TERM && cnt_ff == CNT_TERM)
        |=> eoc_ff && cnt_ff == CNT_ZERO && state_ff == TS_IDLE)
        else $error("single pass did not halt at zero");
    a_stop_holds: assert property (
        (!bus.load && !bus.run) |=> $stable(cnt_ff) && $stable(pre_ff))
        else $error("stopped counter moved");
    a_eoc_cause: assert property (
        eoc_ff |-> $past(pre_ff) == PRE_TERM && $past(cnt_ff) == CNT_TERM)
        else $error("end of count without terminal state");

endmodule : tpiu_timer

// ### src/tpiu_top.sv
// Summary of operation
// - Two 8-bit timers, own 6-bit prescalers
// - Timer one prescaler may use external clock
// - Prescaler divides by 1 through 64
// - Counter decrements per prescaler end, span 1-256
// - Both at end raise timer request
// - Start, stop, continue, or restart from initial
// - Single-pass halts; continuous reloads and continues
// - Counts readable undisturbed; prescalers write-only
// - Timer one source: clock/4 or pin
// - Pin acts as clock, triggers, or gate
// - Six sources: edges and timer ends
// - Mask per source plus global enable
// - Programmable priority picks among pending requests
// - Grant disables interrupts and vectors core
// - Vector pair holds 16-bit routine address
// - Vector pairs 0,1 through 10,11 per source
// - Timers and edges run while halted
`timescale 1ns/1ns
module tpiu_top
    import tpiu_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        port_in_first,
    input  wire logic        port_in_second,
    input  wire logic        port_in_third,
    input  wire logic        int_ack,
    output logic             int_req,
    output logic      [3:0]  int_vector
);

    // *****************************************
    // Declarations
    // *****************************************
    logic        wait_ff, nxt_wait;
    logic [31:0] rdata_ff, nxt_rdata;
    logic [7:0]  mode_ff, nxt_mode;
    logic        load0_ff, nxt_load0;
    logic        load1_ff, nxt_load1;
    logic [7:0]  init0_ff, nxt_init0;
    logic [7:0]  init1_ff, nxt_init1;
    logic [7:0]  pre0_ff, nxt_pre0;
    logic [7:0]  pre1_ff, nxt_pre1;
    logic [2:0]  prio_ff, nxt_prio;
    logic [5:0]  req_ff, nxt_req;
    logic [7:0]  mask_ff, nxt_mask;
    logic        ireq_ff, nxt_ireq;
    logic [2:0]  sel_ff, nxt_sel;
    logic [2:0]  prev_ff;
    logic [1:0]  div_ff;
    logic        wr_go;
    logic        tick4;
    logic        fall_a, fall_b, fall_c, rise_b;
    logic [5:0]  set_req;
    logic [5:0]  pend;
    logic        found;
    logic [2:0]  pick;
    logic [3:0]  idx;
    tpiu_tin_e   tin_mode;
    logic        t1_ext;

    tpiu_tmr_if t0_if ();
    tpiu_tmr_if t1_if ();

    // *****************************************
    // Avalon slave: one wait cycle
    // *****************************************
    assign wr_go = avs_write && !wait_ff;

    always_comb
    begin
        nxt_wait  = 1'b1;
        nxt_rdata = rdata_ff;
        if ((avs_read || avs_write) && wait_ff)
        begin
            nxt_wait  = 1'b0;
            nxt_rdata = RD_ZERO;
            unique case (avs_address)
                OFS_MODE: nxt_rdata[7:0] = mode_ff;
                OFS_CNT1: nxt_rdata[7:0] = t1_if.count;
                OFS_CNT0: nxt_rdata[7:0] = t0_if.count;
                OFS_REQ:  nxt_rdata[5:0] = req_ff;
                OFS_MASK: nxt_rdata[7:0] = mask_ff;
                default:  nxt_rdata = RD_ZERO;
            endcase
        end
    end

    // *****************************************
    // Timer control registers
    // *****************************************
    always_comb
    begin
        nxt_mode  = mode_ff;
        nxt_load0 = 1'b0;
        nxt_load1 = 1'b0;
        nxt_init0 = init0_ff;
        nxt_init1 = init1_ff;
        nxt_pre0  = pre0_ff;
        nxt_pre1  = pre1_ff;
        nxt_prio  = prio_ff;
        if (wr_go)
        begin
            unique case (avs_address)
                OFS_MODE:
                begin
                    nxt_mode           = avs_writedata[7:0];
                    nxt_mode[MB_LOAD0] = 1'b0;
                    nxt_mode[MB_LOAD1] = 1'b0;
                    nxt_load0 = avs_writedata[MB_LOAD0];
                    nxt_load1 = avs_writedata[MB_LOAD1];
                end
                OFS_CNT1: nxt_init1 = avs_writedata[7:0];
                OFS_CNT0: nxt_init0 = avs_writedata[7:0];
                OFS_PRE1: nxt_pre1  = avs_writedata[7:0];
                OFS_PRE0: nxt_pre0  = avs_writedata[7:0];
                OFS_PRIO: nxt_prio  = avs_writedata[2:0];
                default:  nxt_mode  = mode_ff;
            endcase
        end
    end

    // *****************************************
    // Timer sources and hookup
    // *****************************************
    assign tick4    = (div_ff == DIV4_LAST);
    assign fall_a   = prev_ff[0] && !port_in_first;
    assign fall_b   = prev_ff[1] && !port_in_second;
    assign rise_b   = !prev_ff[1] && port_in_second;
    assign fall_c   = prev_ff[2] && !port_in_third;
    assign tin_mode = tpiu_tin_e'(mode_ff[MB_TIN_HI:MB_TIN_LO]);
    assign t1_ext   = !pre1_ff[PB_INT];

    assign t0_if.tick     = tick4;
    assign t0_if.load     = load0_ff;
    assign t0_if.run      = mode_ff[MB_RUN0];
    assign t0_if.cont     = pre0_ff[PB_CONT];
    assign t0_if.init_val = init0_ff;
    assign t0_if.pre_val  = pre0_ff[PB_DIV_HI:PB_DIV_LO];

    // External clock, gate, or triggered internal clock
    assign t1_if.tick = (t1_ext && tin_mode == TIN_EXTCLK) ? fall_a
                      : tick4 && (tin_mode != TIN_GATE || port_in_first);
    assign t1_if.load = load1_ff || (fall_a && (tin_mode == TIN_RETRIG
                      || (tin_mode == TIN_TRIG && !t1_if.busy)));
    assign t1_if.run      = mode_ff[MB_RUN1];
    assign t1_if.cont     = pre1_ff[PB_CONT];
    assign t1_if.init_val = init1_ff;
    assign t1_if.pre_val  = pre1_ff[PB_DIV_HI:PB_DIV_LO];

    tpiu_timer u_timer_zero (
        .clk    (clk),
        .arst_n (arst_n),
        .bus    (t0_if)
    );

    tpiu_timer u_timer_one (
        .clk    (clk),
        .arst_n (arst_n),
        .bus    (t1_if)
    );

    // *****************************************
    // Interrupt requests, mask, priority
    // *****************************************
    always_comb
    begin
        set_req             = REQ_RST;
        set_req[SRC_FALL_B] = fall_b;
        set_req[SRC_FALL_C] = fall_c;
        set_req[SRC_FALL_A] = fall_a;
        set_req[SRC_RISE_B] = rise_b;
        set_req[SRC_T0]     = t0_if.eoc;
        set_req[SRC_T1]     = t1_if.eoc;
        pend = req_ff & mask_ff[NSRC-1:0];
        found = 1'b0;
        pick  = 3'h0;
        // Round from the programmed top source
        for (int k = 0; k < NSRC; k++)
        begin
            idx = {1'b0, (prio_ff < NSRC_W[2:0]) ? prio_ff : PRIO_RST}
                + 4'(k);
            if (idx >= NSRC_W)
                idx = idx - NSRC_W;
            if (!found && pend[idx[2:0]])
            begin
                found = 1'b1;
                pick  = idx[2:0];
            end
        end
    end

    always_comb
    begin
        nxt_req  = req_ff;
        nxt_mask = mask_ff;
        if (wr_go && avs_address == OFS_REQ)
            nxt_req = avs_writedata[5:0];
        if (wr_go && avs_address == OFS_MASK)
            nxt_mask = avs_writedata[7:0];
        if (int_ack && ireq_ff)
        begin
            nxt_req[sel_ff]     = 1'b0;
            nxt_mask[MK_GLOBAL] = 1'b0;
        end
        nxt_req  = nxt_req | set_req;
        nxt_ireq = found && mask_ff[MK_GLOBAL] && !(int_ack && ireq_ff);
        nxt_sel  = pick;
    end

    // *****************************************
    // Registers
    // *****************************************
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wait_ff  <= 1'b1;
            rdata_ff <= RD_ZERO;
            mode_ff  <= MODE_RST;
            load0_ff <= 1'b0;
            load1_ff <= 1'b0;
            init0_ff <= BYTE_RST;
            init1_ff <= BYTE_RST;
            pre0_ff  <= BYTE_RST;
            pre1_ff  <= BYTE_RST;
            prio_ff  <= PRIO_RST;
            req_ff   <= REQ_RST;
            mask_ff  <= BYTE_RST;
            ireq_ff  <= 1'b0;
            sel_ff   <= PRIO_RST;
            prev_ff  <= 3'h7;
            div_ff   <= 2'h0;
        end
        else
        begin
            wait_ff  <= nxt_wait;
            rdata_ff <= nxt_rdata;
            mode_ff  <= nxt_mode;
            load0_ff <= nxt_load0;
            load1_ff <= nxt_load1;
            init0_ff <= nxt_init0;
            init1_ff <= nxt_init1;
            pre0_ff  <= nxt_pre0;
            pre1_ff  <= nxt_pre1;
            prio_ff  <= nxt_prio;
            req_ff   <= nxt_req;
            mask_ff  <= nxt_mask;
            ireq_ff  <= nxt_ireq;
            sel_ff   <= nxt_sel;
            prev_ff  <= {port_in_third, port_in_second, port_in_first};
            div_ff   <= div_ff + 2'h1;
        end
    end

    assign avs_readdata    = rdata_ff;
    assign avs_waitrequest = wait_ff;
    assign int_req         = ireq_ff;
    assign int_vector      = {sel_ff, 1'b0};

    // *****************************************
    // Assertions
    // *****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    a_edge_b_sets: assert property (
        (prev_ff[1] && !port_in_second) |=> req_ff[SRC_FALL_B])
        else $error("falling edge lost");
    a_timer_sets: assert property (
        t1_if.eoc |=> req_ff[SRC_T1])
        else $error("timer one end lost");
    a_global_mask: assert property (
        !mask_ff[MK_GLOBAL] |=> !int_req)
        else $error("request with global enable off");
    a_grant_disables: assert property (
        (int_ack && int_req) |=> !mask_ff[MK_GLOBAL] && !int_req
        ##1 !int_req)
        else $error("grant did not disable");
    a_vector_pending: assert property (
        int_req |-> |($past(pend) & (6'h01 << int_vector[3:1])))
        else $error("vector names non pending source");
    a_div_four: assert property (
        tick4 |=> !tick4 [*3] ##1 tick4)
        else $error("clock divide not four");
    a_bus_answer: assert property (
        ((avs_read || avs_write) && wait_ff) |=> !avs_waitrequest
        ##1 avs_waitrequest)
        else $error("bus answer not one cycle");

    c_timer0_end: cover property (t0_if.eoc);
    c_grant: cover property (int_req && int_ack);
    c_retrigger: cover property (t1_if.busy && t1_if.load);
    c_two_pending: cover property ($countones(req_ff) > 1 && int_req);

endmodule : tpiu_top

// ### verification/tpiu_core_model.sv
`timescale 1ns/1ns
module tpiu_core_model
    import tpiu_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       int_req,
    input  wire logic [3:0] int_vector,
    input  wire logic [3:0] ack_delay,
    output logic            int_ack,
    output logic      [3:0] vec_seen,
    output logic      [7:0] grants
);
    logic [3:0] wait_ff;

    // ****************************************
    // Grant after a programmable wait
    // ****************************************
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            int_ack  <= 1'b0;
            wait_ff  <= 4'h0;
            vec_seen <= 4'h0;
            grants   <= 8'h00;
        end
        else
        begin
            int_ack <= 1'b0;
            if (int_req && !int_ack)
            begin
                if (wait_ff == ack_delay)
                begin
                    int_ack  <= 1'b1;
                    vec_seen <= int_vector;
                    grants   <= grants + 8'h01;
                    wait_ff  <= 4'h0;
                end
                else
                    wait_ff <= wait_ff + 4'h1;
            end
        end
    end
endmodule : tpiu_core_model

// ### verification/test_timer_pair_with_irq_unit.sv
`timescale 1ns/1ns
module test_timer_pair_with_irq_unit
    import tpiu_pkg::*;
;
    logic        clk, arst_n, avs_read, avs_write, avs_waitrequest;
    logic [7:0]  avs_address, grants;
    logic [31:0] avs_writedata, avs_readdata;
    logic        port_in_first, port_in_second, port_in_third;
    logic        int_ack, int_req;
    logic [3:0]  int_vector, vec_seen, ack_delay;
    int          mismatches, checks, cyc;

    tpiu_top dut_u (.clk(clk), .arst_n(arst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .port_in_first(port_in_first), .port_in_second(port_in_second),
        .port_in_third(port_in_third), .int_ack(int_ack), .int_req(int_req),
        .int_vector(int_vector));

    tpiu_core_model core_u (.clk(clk), .arst_n(arst_n), .int_req(int_req),
        .int_vector(int_vector), .ack_delay(ack_delay), .int_ack(int_ack),
        .vec_seen(vec_seen), .grants(grants));

    // ****************************************
    // Helpers
    // ****************************************
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) cyc++;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk

    task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clk);
        avs_address   <= a;
        avs_writedata <= wd;
        avs_write     <= we;
        avs_read      <= !we;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0)
        begin
            @(posedge clk);
            n++;
        end
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        chk(n, 32'h1, "bus answer");
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string m);
        logic [31:0] x;
        bus(1'b0, a, 32'h0, x);
        chk(x, e, m);
    endtask : rdc

    task automatic poll(input int b, output logic hit);
        logic [31:0] x;
        int n;
        x = 32'h0;
        for (n = 0; n < 30 && x[b] !== 1'b1; n++)
            bus(1'b0, OFS_REQ, 32'h0, x);
        hit = x[b];
    endtask : poll

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        chk({31'h0, int_req}, 32'h0, "int_req at reset");
        rdc(8'h20, 32'h0, "unmapped read");
        wr(8'h20, 32'hff);
        rdc(OFS_MASK, 32'h0, "mask reset");
        rdc(OFS_REQ, 32'h0, "req reset");
        $display("done reset");
    endtask : t_reset

    task automatic t_poll();
        wr(OFS_REQ, 32'h0);
        port_in_first <= 1'b0;
        repeat (3) @(posedge clk);
        rdc(OFS_REQ, 32'h04, "fall first");
        port_in_second <= 1'b0;
        repeat (3) @(posedge clk);
        rdc(OFS_REQ, 32'h05, "fall second");
        port_in_third <= 1'b0;
        repeat (3) @(posedge clk);
        rdc(OFS_REQ, 32'h07, "fall third");
        port_in_second <= 1'b1;
        port_in_first  <= 1'b1;
        port_in_third  <= 1'b1;
        repeat (3) @(posedge clk);
        rdc(OFS_REQ, 32'h0f, "rise second");
        chk({31'h0, int_req}, 32'h0, "masked");
        $display("done poll");
    endtask : t_poll

    task automatic t_timers();
        logic        h;
        logic [31:0] d;
        int          c0;
        wr(OFS_REQ, 32'h0);
        wr(OFS_PRE0, 32'h0a);
        wr(OFS_CNT0, 32'h03);
        c0 = cyc;
        wr(OFS_MODE, 32'h03);
        poll(SRC_T0, h);
        chk({31'h0, h}, 32'h1, "t0 end");
        chk({31'h0, cyc - c0 >= 20 && cyc - c0 <= 45}, 32'h1, "t0 span");
        rdc(OFS_CNT0, 32'h0, "t0 halted");
        wr(OFS_REQ, 32'h0);
        repeat (60) @(posedge clk);
        rdc(OFS_REQ, 32'h0, "single pass");
        rdc(OFS_PRE0, 32'h0, "pre0 hidden");
        wr(OFS_PRE1, 32'h07);
        wr(OFS_CNT1, 32'h02);
        wr(OFS_MODE, 32'h0c);
        poll(SRC_T1, h);
        chk({31'h0, h}, 32'h1, "t1 end");
        wr(OFS_REQ, 32'h0);
        poll(SRC_T1, h);
        chk({31'h0, h}, 32'h1, "t1 reload");
        wr(OFS_MODE, 32'h0);
        bus(1'b0, OFS_CNT1, 32'h0, d);
        repeat (20) @(posedge clk);
        rdc(OFS_CNT1, d, "t1 stopped");
        wr(OFS_PRE1, 32'h05);
        wr(OFS_REQ, 32'h0);
        wr(OFS_MODE, 32'h0c);
        repeat (20) @(posedge clk);
        rdc(OFS_REQ, 32'h0, "no pin tick");
        repeat (2)
        begin
            port_in_first <= 1'b0;
            repeat (2) @(posedge clk);
            port_in_first <= 1'b1;
            repeat (2) @(posedge clk);
        end
        repeat (3) @(posedge clk);
        rdc(OFS_REQ, 32'h24, "pin clock");
        wr(OFS_PRE1, 32'h06);
        wr(OFS_CNT1, 32'h04);
        wr(OFS_MODE, 32'h2c);
        repeat (30) @(posedge clk);
        wr(OFS_REQ, 32'h0);
        port_in_first <= 1'b0;
        repeat (2) @(posedge clk);
        port_in_first <= 1'b1;
        repeat (30) @(posedge clk);
        rdc(OFS_REQ, 32'h24, "pin trigger");
        port_in_first <= 1'b0;
        wr(OFS_MODE, 32'h1c);
        wr(OFS_REQ, 32'h0);
        repeat (30) @(posedge clk);
        rdc(OFS_CNT1, 32'h04, "gate shut");
        port_in_first <= 1'b1;
        repeat (30) @(posedge clk);
        rdc(OFS_REQ, 32'h20, "gate open");
        wr(OFS_CNT1, 32'h10);
        wr(OFS_MODE, 32'h3c);
        wr(OFS_REQ, 32'h0);
        repeat (5)
        begin
            repeat (20) @(posedge clk);
            port_in_first <= 1'b0;
            repeat (2) @(posedge clk);
            port_in_first <= 1'b1;
        end
        rdc(OFS_REQ, 32'h04, "retrigger");
        wr(OFS_MODE, 32'h0);
        $display("done timers");
    endtask : t_timers

    task automatic t_grant();
        logic [7:0] req [6] = '{8'h21, 8'h03, 8'h06, 8'h0c, 8'h18, 8'h30};
        logic [7:0] g;
        int         n;
        for (int i = 0; i < 6; i++)
        begin
            wr(OFS_MASK, 32'h0);
            wr(OFS_PRIO, 32'(i));
            wr(OFS_REQ, {24'h0, req[i]});
            g = grants;
            ack_delay <= 4'(i);
            wr(OFS_MASK, 32'hbf);
            for (n = 0; n < 40 && grants == g; n++)
                @(posedge clk);
            chk({24'h0, grants}, {24'h0, g + 8'h01}, "grant seen");
            chk({28'h0, vec_seen}, 32'(2 * i), "vector");
            repeat (2) @(posedge clk);
            chk({31'h0, int_req}, 32'h0, "req dropped");
            rdc(OFS_REQ, {24'h0, req[i] & ~(8'h01 << i)}, "grant clear");
            rdc(OFS_MASK, 32'h3f, "global off");
        end
        $display("done grant");
    endtask : t_grant

    // ****************************************
    // Run control
    // ****************************************
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : stop_test

    initial
    begin
        #300000;
        mismatches++;
        $display("unexpected at %0t: timeout", $time);
        stop_test();
    end

    initial
    begin
        arst_n         = 1'b0;
        avs_address    = 8'h00;
        avs_read       = 1'b0;
        avs_write      = 1'b0;
        avs_writedata  = 32'h0;
        port_in_first  = 1'b1;
        port_in_second = 1'b1;
        port_in_third  = 1'b1;
        ack_delay      = 4'h0;
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        t_reset();
        t_poll();
        t_timers();
        t_grant();
        stop_test();
    end
endmodule : test_timer_pair_with_irq_unit
